// ==== rtl/lpm_ctrl.sv ====
// The register addresses and the APB interface to the registers were chosen for this implementation.
`include "lpm_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module lpm_ctrl #(
    parameter int SLEEP_WAKE_CYC = `LPM_SLEEP_WAKE_CYC,
    parameter int IDLE_WAKE_CYC  = `LPM_IDLE_WAKE_CYC
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // core events
    input  wire logic             halt_instr_exec,
    input  wire logic             sleep_instruction,
    input  wire logic             interrupt_enable_flag,
    input  wire lpm_pkg::lpm_irq_t irq_in,
    // external bus masters
    input  wire logic             bus_req,
    output logic                  bus_grant,
    // pins and enables
    output logic                  halt_status_out,
    output logic                  cycle_status_out,
    output logic                  opcode_fetch_strobe,
    output logic                  system_clock_out_en,
    output logic                  core_exec_en,
    output logic                  opcode_refetch,
    output logic                  periph_run_en,
    output logic                  refresh_en,
    output logic                  dma_run_en,
    output logic                  irq_service,
    output logic                  resume_next
);

    // refuse latencies the 4-bit wake counter cannot hold
    if (SLEEP_WAKE_CYC < 1 || SLEEP_WAKE_CYC > 15 || IDLE_WAKE_CYC < 1 || IDLE_WAKE_CYC > 15) begin : g_bad_wake
        $error("wake latency must be 1..15 cycles");
    end

    localparam logic [3:0] SLEEP_CNT = 4'(SLEEP_WAKE_CYC - 1);
    localparam logic [3:0] IDLE_CNT  = 4'(IDLE_WAKE_CYC - 1);

    lpm_pkg::lpm_state_t st_reg;
    lpm_pkg::lpm_state_t st_next;

    logic io_stop;
    logic idle_cfg;
    logic [2:0] mask_hit;
    logic ext_wake;
    logic sleep_wake;
    logic any_wake;
    logic wr_en;

    // register address check
    function automatic logic lpm_mapped(input logic [7:0] a);
        return a == `LPM_OFF_IO_CTRL || a == `LPM_OFF_PROC_CTRL ||
               a == `LPM_OFF_IRQ_EN || a == `LPM_OFF_STATUS;
    endfunction

    // wake source decode
    assign io_stop    = st_reg.io_ctrl[`LPM_IO_STOP_BIT];
    assign idle_cfg   = io_stop && !st_reg.proc_ctrl[`LPM_PC_IDLE_CLR_BIT]
                        && st_reg.proc_ctrl[`LPM_PC_IDLE_SET_BIT];
    assign mask_hit   = irq_in.maskable & st_reg.irq_en;
    assign ext_wake   = irq_in.nmi || (|mask_hit);
    assign sleep_wake = ext_wake || (irq_in.internal && !io_stop);
    assign any_wake   = ext_wake || irq_in.internal;
    assign wr_en      = psel && penable && pwrite;

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.service_pulse = 1'b0;
        st_next.resume_pulse  = 1'b0;
        // register writes
        if (wr_en) begin
            unique case (paddr)
                `LPM_OFF_IO_CTRL:   st_next.io_ctrl   = pwdata[7:0];
                `LPM_OFF_PROC_CTRL: st_next.proc_ctrl = pwdata[7:0];
                `LPM_OFF_IRQ_EN:    st_next.irq_en    = pwdata[2:0];
                default: ;
            endcase
        end
        if (psel && !penable) begin
            st_next.pslverr = !lpm_mapped(paddr) || (pwrite && paddr == `LPM_OFF_STATUS);
            unique case (paddr)
                `LPM_OFF_IO_CTRL:   st_next.prdata = {24'h000000, st_reg.io_ctrl};
                `LPM_OFF_PROC_CTRL: st_next.prdata = {24'h000000, st_reg.proc_ctrl};
                `LPM_OFF_IRQ_EN:    st_next.prdata = {29'h0, st_reg.irq_en};
                `LPM_OFF_STATUS:    st_next.prdata = {24'h000000, st_reg.bus_idle_latch, 4'h0, st_reg.mode};
                default:            st_next.prdata = 32'h00000000;
            endcase
        end
        // mode sequencing
        unique case (st_reg.mode)
            lpm_pkg::LPM_RUN: begin
                if (sleep_instruction) begin
                    if (idle_cfg) begin
                        st_next.mode = lpm_pkg::LPM_IDLE;
                        st_next.bus_idle_latch = st_reg.proc_ctrl[`LPM_PC_BUS_IDLE_BIT];
                    end else if (io_stop) begin
                        st_next.mode = lpm_pkg::LPM_SYS_STOP;
                    end else begin
                        st_next.mode = lpm_pkg::LPM_SLEEP;
                    end
                end else if (halt_instr_exec) begin
                    st_next.mode = lpm_pkg::LPM_HALT;
                end
            end
            lpm_pkg::LPM_HALT: begin
                if (any_wake) begin
                    st_next.mode = lpm_pkg::LPM_RUN;
                    st_next.service_pulse = 1'b1;
                end
            end
            lpm_pkg::LPM_SLEEP, lpm_pkg::LPM_SYS_STOP: begin
                if ((st_reg.mode == lpm_pkg::LPM_SLEEP) ? any_wake : sleep_wake) begin
                    st_next.mode = lpm_pkg::LPM_WAKE;
                    st_next.wake_cnt = SLEEP_CNT;
                    st_next.wake_service = irq_in.nmi || interrupt_enable_flag;
                end
            end
            lpm_pkg::LPM_IDLE: begin
                if (ext_wake) begin
                    st_next.mode = lpm_pkg::LPM_WAKE;
                    st_next.wake_cnt = IDLE_CNT;
                    st_next.wake_service = irq_in.nmi || interrupt_enable_flag;
                end
            end
            lpm_pkg::LPM_WAKE: begin
                if (st_reg.wake_cnt == 4'h0) begin
                    st_next.mode = lpm_pkg::LPM_RUN;
                    st_next.bus_idle_latch = 1'b0;
                    st_next.service_pulse = st_reg.wake_service;
                    st_next.resume_pulse  = !st_reg.wake_service;
                end else begin
                    st_next.wake_cnt = st_reg.wake_cnt - 4'h1;
                end
            end
            default: st_next.mode = lpm_pkg::LPM_RUN;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{mode: lpm_pkg::LPM_RUN, wake_cnt: 4'h0, wake_service: 1'b0,
                        bus_idle_latch: 1'b0, io_ctrl: `LPM_IO_CTRL_RST,
                        proc_ctrl: `LPM_PROC_CTRL_RST, irq_en: `LPM_IRQ_EN_RST,
                        prdata: 32'h00000000, pslverr: 1'b0, service_pulse: 1'b0,
                        resume_pulse: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // bus answer
    assign pready  = 1'b1;
    assign prdata  = st_reg.prdata;
    assign pslverr = st_reg.pslverr;

    // outputs decoded from mode
    always_comb begin
        halt_status_out     = st_reg.mode != lpm_pkg::LPM_HALT;
        cycle_status_out    = st_reg.mode != lpm_pkg::LPM_HALT;
        opcode_fetch_strobe = st_reg.mode != lpm_pkg::LPM_HALT;
        opcode_refetch      = st_reg.mode == lpm_pkg::LPM_HALT;
        core_exec_en        = st_reg.mode == lpm_pkg::LPM_RUN;
        system_clock_out_en = !(st_reg.mode == lpm_pkg::LPM_IDLE ||
                                (st_reg.mode == lpm_pkg::LPM_WAKE && st_reg.bus_idle_latch));
        periph_run_en       = !io_stop && st_reg.mode != lpm_pkg::LPM_IDLE;
        refresh_en          = st_reg.mode != lpm_pkg::LPM_IDLE;
        dma_run_en          = st_reg.mode != lpm_pkg::LPM_IDLE;
        bus_grant           = bus_req && (st_reg.mode != lpm_pkg::LPM_IDLE || st_reg.bus_idle_latch);
        irq_service         = st_reg.service_pulse;
        resume_next         = st_reg.resume_pulse;
    end

    // checks
    property p_halt_pins;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_HALT) |-> (!halt_status_out && !cycle_status_out && !opcode_fetch_strobe);
    endproperty
    a_halt_pins: assert property (p_halt_pins) else $error("halt pins not low");

    property p_run_high;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_RUN) |-> (halt_status_out && core_exec_en);
    endproperty
    a_run_high: assert property (p_run_high) else $error("run without halt status high");

    property p_sleep_wake;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_SLEEP && any_wake) |-> ##(2) st_reg.mode == lpm_pkg::LPM_WAKE
            ##1 st_reg.mode == lpm_pkg::LPM_RUN;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake latency wrong");

    property p_io_stop;
        @(posedge pclk) disable iff (!presetn)
        io_stop |-> !periph_run_en;
    endproperty
    a_io_stop: assert property (p_io_stop) else $error("peripherals run under io stop");

    property p_sys_stop_entry;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_RUN && sleep_instruction && io_stop && !idle_cfg)
            |=> (st_reg.mode == lpm_pkg::LPM_SYS_STOP && system_clock_out_en && !core_exec_en);
    endproperty
    a_sys_stop_entry: assert property (p_sys_stop_entry) else $error("system stop not entered");

    property p_sys_stop_internal;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_SYS_STOP && !ext_wake) |=> st_reg.mode == lpm_pkg::LPM_SYS_STOP;
    endproperty
    a_sys_stop_internal: assert property (p_sys_stop_internal) else $error("internal wake in system stop");

    property p_idle_gate;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_IDLE) |-> (!system_clock_out_en && !refresh_en && !periph_run_en);
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("clock not gated in idle");

    property p_idle_bus;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_IDLE && !st_reg.bus_idle_latch) |-> !bus_grant;
    endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("bus granted in idle");

    property p_idle_wake;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_IDLE && ext_wake) |=> (st_reg.mode == lpm_pkg::LPM_WAKE) [*5]
            ##1 (st_reg.mode == lpm_pkg::LPM_WAKE) [*5]
            ##1 (st_reg.mode == lpm_pkg::LPM_RUN);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake latency wrong");

    property p_idle_service;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_IDLE && irq_in.nmi) |-> ##11 (irq_service && !resume_next);
    endproperty
    a_idle_service: assert property (p_idle_service) else $error("nmi not serviced after idle");

    property p_idle_resume;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_IDLE && !irq_in.nmi && (|mask_hit) && !interrupt_enable_flag)
            |-> ##11 (resume_next && !irq_service);
    endproperty
    a_idle_resume: assert property (p_idle_resume) else $error("no plain resume after idle");

    // halt leaves clock, memory, transfers and bus alone
    property p_halt_alive;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_HALT) |-> (system_clock_out_en && refresh_en && dma_run_en
            && (periph_run_en == !io_stop) && (bus_grant == bus_req));
    endproperty
    a_halt_alive: assert property (p_halt_alive) else $error("halt stopped a running unit");

    // nmi, an enabled line or an internal request ends halt with a service pulse
    property p_halt_exit;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_HALT && any_wake) |=> (st_reg.mode == lpm_pkg::LPM_RUN && irq_service);
    endproperty
    a_halt_exit: assert property (p_halt_exit) else $error("halt not left on request");

    // peripherals run whenever io stop is clear outside idle
    property p_io_resume;
        @(posedge pclk) disable iff (!presetn)
        (!io_stop && st_reg.mode != lpm_pkg::LPM_IDLE) |-> periph_run_en;
    endproperty
    a_io_resume: assert property (p_io_resume) else $error("peripherals held without io stop");

    // sleep without io stop halts the core only
    property p_plain_sleep;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_RUN && sleep_instruction && !io_stop)
            |=> (st_reg.mode == lpm_pkg::LPM_SLEEP && !core_exec_en);
    endproperty
    a_plain_sleep: assert property (p_plain_sleep) else $error("plain sleep not entered");

    // the full software sequence lands in idle
    property p_idle_entry;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_RUN && sleep_instruction && idle_cfg)
            |=> (st_reg.mode == lpm_pkg::LPM_IDLE);
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

    // grant enable is frozen at idle entry
    property p_idle_latch;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_RUN && sleep_instruction && idle_cfg)
            |=> (st_reg.bus_idle_latch == $past(st_reg.proc_ctrl[`LPM_PC_BUS_IDLE_BIT]));
    endproperty
    a_idle_latch: assert property (p_idle_latch) else $error("idle grant enable not latched");

    // nothing but nmi or an enabled line ends idle
    property p_idle_hold;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_IDLE && !ext_wake)
            |=> (st_reg.mode == lpm_pkg::LPM_IDLE);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle left without a request");

    // external requests still end system stop
    property p_sys_stop_wake;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_SYS_STOP && ext_wake)
            |=> (st_reg.mode == lpm_pkg::LPM_WAKE);
    endproperty
    a_sys_stop_wake: assert property (p_sys_stop_wake) else $error("system stop ignored a request");

    // core stays stopped while restarting
    property p_wake_core;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.mode == lpm_pkg::LPM_WAKE) |-> !core_exec_en;
    endproperty
    a_wake_core: assert property (p_wake_core) else $error("core ran during restart");

    // exit pulses last a single cycle
    property p_pulse_once;
        @(posedge pclk) disable iff (!presetn)
        (irq_service || resume_next) |=> !(irq_service || resume_next);
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("exit pulse longer than one cycle");

endmodule
`default_nettype wire

// ==== rtl/lpm_defines.svh ====
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

// register byte offsets
`define LPM_OFF_IO_CTRL     8'h00
`define LPM_OFF_PROC_CTRL   8'h04
`define LPM_OFF_IRQ_EN      8'h08
`define LPM_OFF_STATUS      8'h0c

// field positions
`define LPM_IO_STOP_BIT     5
`define LPM_PC_IDLE_CLR_BIT 6
`define LPM_PC_IDLE_SET_BIT 3
`define LPM_PC_BUS_IDLE_BIT 5

// reset values
`define LPM_IO_CTRL_RST     8'h00
`define LPM_PROC_CTRL_RST   8'h00
`define LPM_IRQ_EN_RST      3'h0

// restart latencies in tenths of a clock period
`define LPM_SLEEP_WAKE_TENTHS 15
`define LPM_IDLE_WAKE_TENTHS  95
// rounded up to whole cycles
`define LPM_SLEEP_WAKE_CYC  ((`LPM_SLEEP_WAKE_TENTHS + 9) / 10)
`define LPM_IDLE_WAKE_CYC   ((`LPM_IDLE_WAKE_TENTHS + 9) / 10)

`endif

// ==== rtl/lpm_pkg.sv ====
package lpm_pkg;

    typedef enum logic [2:0] {
        LPM_RUN,
        LPM_HALT,
        LPM_SLEEP,
        LPM_SYS_STOP,
        LPM_IDLE,
        LPM_WAKE
    } lpm_mode_t;

    typedef struct packed {
        logic [2:0] maskable;
        logic       nmi;
        logic       internal;
    } lpm_irq_t;

    typedef struct packed {
        lpm_mode_t  mode;
        logic [3:0] wake_cnt;
        logic       wake_service;
        logic       bus_idle_latch;
        logic [7:0] io_ctrl;
        logic [7:0] proc_ctrl;
        logic [2:0] irq_en;
        logic [31:0] prdata;
        logic       pslverr;
        logic       service_pulse;
        logic       resume_pulse;
    } lpm_state_t;

endpackage

// ==== verification/lpm_irq_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module lpm_irq_model (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // raise commands and device acknowledge
    input  wire lpm_pkg::lpm_irq_t raise,
    input  wire logic              ack,
    // request lines to the device
    output lpm_pkg::lpm_irq_t      irq
);
    // level requests stay up until the device services or resumes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= '0;
        end else if (raise != '0) begin
            irq <= irq | raise;
        end else if (ack) begin
            irq <= '0;
        end
    end
endmodule

`default_nettype wire

// ==== verification/tb_low_power_mode_control.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lpm_defines.svh"

module tb_low_power_mode_control;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd, rnd;
    logic              halt_instr_exec, sleep_instruction, interrupt_enable_flag, bus_req, bus_grant;
    logic              halt_status_out, cycle_status_out, opcode_fetch_strobe, system_clock_out_en;
    logic              core_exec_en, opcode_refetch, periph_run_en, refresh_en, dma_run_en;
    logic              irq_service, resume_next, er, flag;
    lpm_pkg::lpm_irq_t irq_in, rq;
    wire               ack = irq_service | resume_next;
    int                bad_count, checked, line;

    lpm_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .halt_instr_exec(halt_instr_exec), .sleep_instruction(sleep_instruction),
        .interrupt_enable_flag(interrupt_enable_flag), .irq_in(irq_in), .bus_req(bus_req),
        .bus_grant(bus_grant), .halt_status_out(halt_status_out), .cycle_status_out(cycle_status_out),
        .opcode_fetch_strobe(opcode_fetch_strobe), .system_clock_out_en(system_clock_out_en),
        .core_exec_en(core_exec_en), .opcode_refetch(opcode_refetch), .periph_run_en(periph_run_en),
        .refresh_en(refresh_en), .dma_run_en(dma_run_en), .irq_service(irq_service),
        .resume_next(resume_next));
    lpm_irq_model irq_u (.pclk(pclk), .presetn(presetn), .raise(rq), .ack(ack), .irq(irq_in));

    // clock generation
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // apb master: setup, access held until pready sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic pulse_sleep();
        @(posedge pclk) sleep_instruction <= 1'b1;
        @(posedge pclk) sleep_instruction <= 1'b0;
        cyc(3);
    endtask

    task automatic raise(input lpm_pkg::lpm_irq_t v);
        @(posedge pclk) rq <= v;
        @(posedge pclk) rq <= '0;
    endtask

    // wake latency window and kind of exit
    task automatic wake_wait(input int n, input logic svc);
        int c;
        c = 0;
        while (irq_service !== 1'b1 && resume_next !== 1'b1 && c < 40) begin
            @(posedge pclk);
            #1;
            c++;
        end
        chk({31'h0, c >= n && c <= n + 2}, 32'h1);
        chk({31'h0, irq_service}, {31'h0, svc});
        cyc(2);
    endtask

    // watchdog
    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        {psel, penable, pwrite, halt_instr_exec, sleep_instruction, bus_req} = '0;
        paddr = '0; pwdata = '0; rq = '0; interrupt_enable_flag = 1'b1; presetn = 1'b0;
        bad_count = 0; checked = 0;
        void'($urandom(32'hf52a9e83));
        cyc(4);
        chk({31'h0, halt_status_out}, 32'h1);
        chk(prdata, 32'h0);
        @(posedge pclk) presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, er}, 32'h0);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, pready}, 32'h1);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, `LPM_OFF_STATUS, 32'hff);
        chk({31'h0, er}, 32'h1);
        chk({core_exec_en, halt_status_out}, 2'b11);
        // halt keeps everything else alive
        bus_req <= 1'b1;
        @(posedge pclk) halt_instr_exec <= 1'b1;
        @(posedge pclk) halt_instr_exec <= 1'b0;
        cyc(2);
        chk({halt_status_out, cycle_status_out, opcode_fetch_strobe, opcode_refetch}, 4'b0001);
        chk({system_clock_out_en, periph_run_en, refresh_en, dma_run_en, bus_grant}, 5'h1f);
        raise(5'b00001);
        wake_wait(1, 1'b1);
        // io stop, then system stop
        rnd = $urandom | 32'h20;
        apb(1'b1, `LPM_OFF_IO_CTRL, rnd);
        apb(1'b0, `LPM_OFF_IO_CTRL, 32'h0);
        chk(rd, {24'h0, rnd[7:0]});
        chk({periph_run_en, core_exec_en}, 2'b01);
        apb(1'b1, `LPM_OFF_PROC_CTRL, 32'h0);
        pulse_sleep();
        chk({core_exec_en, periph_run_en, system_clock_out_en}, 3'b001);
        raise(5'b00001);
        cyc(20);
        chk({31'h0, core_exec_en}, 32'h0);
        raise(5'b00010);
        wake_wait(`LPM_SLEEP_WAKE_CYC, 1'b1);
        apb(1'b1, `LPM_OFF_IO_CTRL, 32'h0);
        cyc(1);
        chk({31'h0, periph_run_en}, 32'h1);
        // plain sleep, woken by a peripheral request
        for (int f = 0; f < 2; f++) begin
            @(posedge pclk);
            interrupt_enable_flag <= f[0];
            pulse_sleep();
            chk({core_exec_en, periph_run_en}, 2'b01);
            raise(5'b00001);
            wake_wait(`LPM_SLEEP_WAKE_CYC, f[0]);
        end
        // idle entry and exit, a randomly chosen maskable line in three rounds, then nmi
        for (int k = 0; k < 4; k++) begin
            line = $urandom % 3;
            flag = (k == 0) ? 1'($urandom) : k[1];
            @(posedge pclk);
            bus_req               <= 1'b1;
            interrupt_enable_flag <= flag;
            apb(1'b1, `LPM_OFF_IRQ_EN, 32'(1 << line));
            apb(1'b1, `LPM_OFF_IO_CTRL, 32'h20);
            apb(1'b1, `LPM_OFF_PROC_CTRL, 32'h08 | 32'(k[0]) << 5);
            pulse_sleep();
            chk({system_clock_out_en, refresh_en, periph_run_en, dma_run_en}, 4'h0);
            chk({31'h0, bus_grant}, {31'h0, k[0]});
            apb(1'b0, `LPM_OFF_STATUS, 32'h0);
            chk(rd, {24'h0, k[0], 4'h0, 3'(lpm_pkg::LPM_IDLE)});
            raise(lpm_pkg::lpm_irq_t'(5'(1 << ((line + 1) % 3 + 2))));
            cyc(20);
            chk({31'h0, core_exec_en}, 32'h0);
            if (k == 3) raise(5'b00010);
            else raise(lpm_pkg::lpm_irq_t'(5'(1 << (line + 2))));
            wake_wait(`LPM_IDLE_WAKE_CYC, k == 3 || flag);
        end
        // reset in mid idle brings the core back
        pulse_sleep();
        @(posedge pclk) presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        cyc(2);
        chk({core_exec_en, system_clock_out_en}, 2'b11);
        report_and_stop();
    end
endmodule

`default_nettype wire
